// ### design/rsq_cfg.svh
// Constants of the reset sequencer and lock interrupt block.
// Assumes inclusion by bare name from the design and bench files.
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

// Register indices, byte address is four times the index
`define RSQ_IDX_TRIM   6'h36
`define RSQ_IDX_FLAG   6'h37
`define RSQ_IDX_CTL1   6'h38
`define RSQ_IDX_CTL0   6'h39
`define RSQ_IDX_TEST0  6'h3A
`define RSQ_IDX_TEST1  6'h3B

// Field positions
`define RSQ_FLG_POR    6
`define RSQ_FLG_LOCK_CHANGE_FLAG 4
`define RSQ_FLG_LOCK_STATUS 3
`define RSQ_FLG_ILA    2
`define RSQ_CTL1_LOCK_IRQ_ENABLE 0
`define RSQ_CTL0_OSC_AMP_OUTPUT_OSC_ENABLE 0

// Reset values
`define RSQ_RST_CTL0   8'h00
`define RSQ_RST_CTL1   8'h00
`define RSQ_RST_TRIM   8'h00
`define RSQ_RST_TEST0  8'h00

// Sequence lengths in internal oscillator clock cycles
`define RSQ_DRIVE_CYC  516
`define RSQ_DRIVE_ALT  517
`define RSQ_WAIT_CYC   256
`define RSQ_SEQ_CYC    768

`endif

// ### design/rsq_pkg.sv
// Types shared by the reset sequencer files.
// Assumes rsq_cfg.svh is on the include path.
`default_nettype none

package rsq_pkg;

	// Vector chosen at the sample point of a reset sequence
	typedef enum logic [1:0] {
		vec_ext,
		vec_osc_fail,
		vec_watchdog
	} rsq_vec_e;

	// Sequencer states
	typedef enum logic [1:0] {
		st_idle,
		st_drive,
		st_wait,
		st_hold
	} rsq_state_e;

	// Oscillator modes
	typedef enum logic {
		osc_off,
		osc_full_swing
	} rsq_osc_e;

	// Synchronised inputs from outside the clock domain
	typedef struct packed {
		logic pin_high;
		logic por;
		logic illegal;
		logic wdog;
		logic osc_fail;
		logic lock_det;
	} rsq_evt_s;

endpackage

`default_nettype wire

// ### design/rsq_sync.sv
// Two flip-flop synchroniser for a bundle of levels.
// Assumes each bit is a level held far longer than one clock.
`default_nettype none

module rsq_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ### design/rsq_seq.sv
// Reset sequence counter: pin drive, wait, sample, hold.
// Assumes arst_n combines the bus reset and the power-on detector.
`default_nettype none
`include "rsq_cfg.svh"

module rsq_seq #(
	parameter int DRIVE_CYC = `RSQ_DRIVE_CYC,
	parameter int WAIT_CYC  = `RSQ_WAIT_CYC
) (
	input  wire logic pclk,
	input  wire logic arst_n,
	input  wire logic trig,
	input  wire logic pin_high,
	output logic      drive_low,
	output logic      sys_rst,
	output logic      decide
);

	if (DRIVE_CYC < 2 || WAIT_CYC < 2 || DRIVE_CYC > 1023 ||
	    WAIT_CYC > 1023)
	begin : g_chk
		$error("rsq_seq: cycle counts out of range");
	end

	rsq_pkg::rsq_state_e state_q;
	logic [9:0]          cnt_q;
	logic [10:0]         drv_len_q;

	// Entry is asynchronous, leaving needs the clock
	// R3: async entry, clocked exit
	always_ff @(posedge pclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= rsq_pkg::st_drive;
			cnt_q   <= 10'h000;
		end
		else if (trig)
		begin
			state_q <= rsq_pkg::st_drive;
			cnt_q   <= 10'h000;
		end
		else
		begin
			unique case (state_q)
				rsq_pkg::st_idle: cnt_q <= 10'h000;
				// R2: drive pin for count
				rsq_pkg::st_drive:
					if (cnt_q == 10'(DRIVE_CYC - 1))
					begin
						state_q <= rsq_pkg::st_wait;
						cnt_q   <= 10'h000;
					end
					else
						cnt_q <= cnt_q + 10'h001;
				// R4: wait then sample
				rsq_pkg::st_wait:
					if (cnt_q == 10'(WAIT_CYC - 1))
						state_q <= pin_high ? rsq_pkg::st_idle
						                    : rsq_pkg::st_hold;
					else
						cnt_q <= cnt_q + 10'h001;
				// R7: hold while pin low
				rsq_pkg::st_hold:
					if (pin_high)
						state_q <= rsq_pkg::st_idle;
			endcase
		end
	end

	// R6: internal reset whole sequence
	assign sys_rst   = (state_q != rsq_pkg::st_idle);
	assign drive_low = (state_q == rsq_pkg::st_drive);
	assign decide    = (state_q == rsq_pkg::st_wait) && !trig &&
	                   (cnt_q == 10'(WAIT_CYC - 1));

	// Length of each low drive, for checking only
	always_ff @(posedge pclk or negedge arst_n)
	begin
		if (!arst_n)
			drv_len_q <= 11'h000;
		else if (trig)
			drv_len_q <= 11'h000;
		else if (drive_low)
			drv_len_q <= drv_len_q + 11'h001;
		else
			drv_len_q <= 11'h000;
	end

	drive_len_a: assert property (@(posedge pclk) disable iff (!arst_n) // R2
		$fell(drive_low) |-> drv_len_q == 11'(DRIVE_CYC))
		else $error("reset pin drive length wrong");

	hold_pin_a: assert property (@(posedge pclk) disable iff (!arst_n) // R7
		(state_q == rsq_pkg::st_hold && !pin_high && !trig) |=> sys_rst)
		else $error("internal reset released with pin low");

endmodule

`default_nettype wire

// ### design/rsq_top.sv
// Reset generator, lock interrupt and oscillator control, APB slave.
// Assumes pclk is the internal oscillator clock and pready is
// sampled by an APB master; pins pass a two-stage synchroniser.
`default_nettype none
`include "rsq_cfg.svh"

// Operation
// R1: five events start a reset sequence
// R2: drive reset pin low 516 cycles
// R3: async entry, exit needs running clock
// R4: wait 256 cycles, then sample pin
// R5: vector from pin, then pending causes
// R6: internal reset over whole sequence
// R7: pin held low extends internal reset
// R8: oscillator failure resets only when enabled
// R9: watchdog timeout resets and stays pending
// R10: power-on detection resets as power-on
// R11: lock flag set on status change
// R12: writing one clears lock flag
// R13: lock request gated by enable, mask
// R14: first test register reads zero
// R15: second test register readable, unwritable
// R16: oscillator off or full swing
// R17: amplifier output high while off
// R18: trim/CTL0 writes and stop mode clear status silently
// R19: power-on flag set, write-one clears
// R20: pending causes cleared at vector decision
// R21: pin only pulled low by device
module rsq_top #(
	parameter int         DRIVE_CYC   = `RSQ_DRIVE_CYC,
	parameter int         WAIT_CYC    = `RSQ_WAIT_CYC,
	parameter logic [7:0] TEST1_VALUE = 8'h5A // Arbitrary value
) (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic      [31:0]    prdata,
	output logic                pready,
	output logic                pslverr,
	input  wire logic           rst_pin_in,
	output logic                rst_pin_out,
	output logic                rst_pin_oe_n,
	input  wire logic           por_detect,
	input  wire logic           illegal_access,
	input  wire logic           watchdog_timeout,
	input  wire logic           osc_clk_fail,
	input  wire logic           lock_detect,
	input  wire logic           stop_mode,
	input  wire logic           cpu_irq_mask,
	output logic                sys_reset,
	output rsq_pkg::rsq_vec_e   reset_vector,
	output logic                lock_irq,
	output logic                osc_amp_enable,
	output logic                osc_amp_force_high
);

	////////////////////////////////////////////////////////////////
	// Declarations

	rsq_pkg::rsq_evt_s evt;
	rsq_pkg::rsq_osc_e osc_mode;
	logic              seq_arst_n;
	logic              seq_trig;
	logic              seq_drive_low;
	logic              seq_decide;
	logic              oscf_evt;
	logic              apb_setup;
	logic              apb_access;
	logic              apb_wr;
	logic              apb_mapped;
	logic [5:0]        idx;
	logic [7:0]        rd_val;
	logic [7:0]        flag_val;
	logic              lock_clr;
	logic              lock_st_d;
	logic              lock_change_flag_clr;
	logic              power_on_flag_clr;
	logic              illegal_access_flag_clr;
	logic              osc_amp_output_osc_enable_q;
	logic              lock_irq_enable_q;
	logic [7:0]        trim_q;
	logic              lock_st_q;
	logic              lock_change_flag_q;
	logic              power_on_flag_q;
	logic              illegal_access_flag_q;
	logic              wdog_pend_q;
	logic              oscf_pend_q;

	// True when an access addresses the given register index
	function automatic logic hit(input logic [5:0] a,
	                             input logic [5:0] r);
		return a == r;
	endfunction

	////////////////////////////////////////////////////////////////
	// Input synchronisation and event collection

	rsq_sync #(
		.W ($bits(rsq_pkg::rsq_evt_s))
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({rst_pin_in, por_detect, illegal_access,
		           watchdog_timeout, osc_clk_fail, lock_detect}),
		.q       (evt)
	);

	// R8: monitor failure only when enabled
	assign oscf_evt = evt.osc_fail && osc_amp_output_osc_enable_q;

	// R1: any event restarts the sequence; a low pin only while the sequence is not running
	// R9: watchdog timeout triggers sequence
	assign seq_trig = evt.illegal || evt.wdog || oscf_evt ||
	                  (!evt.pin_high && !sys_reset);

	// R10: power-on detector enters reset asynchronously
	assign seq_arst_n = presetn && !por_detect;

	////////////////////////////////////////////////////////////////
	// Reset sequencer

	rsq_seq #(
		.DRIVE_CYC (DRIVE_CYC),
		.WAIT_CYC  (WAIT_CYC)
	) u_seq (
		.pclk      (pclk),
		.arst_n    (seq_arst_n),
		.trig      (seq_trig),
		.pin_high  (evt.pin_high),
		.drive_low (seq_drive_low),
		.sys_rst   (sys_reset),
		.decide    (seq_decide)
	);

	// R21: open-drain pin, low drive only
	assign rst_pin_out  = 1'b0;
	assign rst_pin_oe_n = !seq_drive_low;

	// Pending watchdog cause, a new event wins over the clear
	// R20: latch until decision
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdog_pend_q <= 1'b0;
		else if (evt.wdog)
			wdog_pend_q <= 1'b1;
		else if (seq_decide)
			wdog_pend_q <= 1'b0;
	end

	// Pending oscillator failure cause
	// R20: latch until decision
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			oscf_pend_q <= 1'b0;
		else if (oscf_evt)
			oscf_pend_q <= 1'b1;
		else if (seq_decide)
			oscf_pend_q <= 1'b0;
	end

	// Vector chosen at the sample point
	// R5: pin, then oscillator, then watchdog
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reset_vector <= rsq_pkg::vec_ext;
		else if (seq_decide)
		begin
			if (!evt.pin_high)
				reset_vector <= rsq_pkg::vec_ext;
			else if (oscf_pend_q)
				reset_vector <= rsq_pkg::vec_osc_fail;
			else if (wdog_pend_q)
				reset_vector <= rsq_pkg::vec_watchdog;
			else
				reset_vector <= rsq_pkg::vec_ext;
		end
	end

	////////////////////////////////////////////////////////////////
	// APB decode

	assign idx        = paddr[7:2];
	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable;
	assign apb_wr     = apb_access && pwrite;
	assign apb_mapped = hit(idx, `RSQ_IDX_TRIM) ||
	                    hit(idx, `RSQ_IDX_FLAG) ||
	                    hit(idx, `RSQ_IDX_CTL1) ||
	                    hit(idx, `RSQ_IDX_CTL0) ||
	                    hit(idx, `RSQ_IDX_TEST0) ||
	                    hit(idx, `RSQ_IDX_TEST1);

	// Zero wait states, error on unmapped words
	assign pready  = apb_access;
	assign pslverr = apb_access && !apb_mapped;

	////////////////////////////////////////////////////////////////
	// Control registers

	// Oscillator enable
	// R16: two modes from one bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			osc_amp_output_osc_enable_q <= 1'(`RSQ_RST_CTL0 >> `RSQ_CTL0_OSC_AMP_OUTPUT_OSC_ENABLE);
		else if (apb_wr && hit(idx, `RSQ_IDX_CTL0))
			osc_amp_output_osc_enable_q <= pwdata[`RSQ_CTL0_OSC_AMP_OUTPUT_OSC_ENABLE];
	end

	// Lock interrupt enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lock_irq_enable_q <= 1'(`RSQ_RST_CTL1 >> `RSQ_CTL1_LOCK_IRQ_ENABLE);
		else if (apb_wr && hit(idx, `RSQ_IDX_CTL1))
			lock_irq_enable_q <= pwdata[`RSQ_CTL1_LOCK_IRQ_ENABLE];
	end

	// Trim value for the internal reference
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trim_q <= `RSQ_RST_TRIM;
		else if (apb_wr && hit(idx, `RSQ_IDX_TRIM))
			trim_q <= pwdata[7:0];
	end

	// R17: amplifier output forced high when off
	assign osc_mode           = osc_amp_output_osc_enable_q ? rsq_pkg::osc_full_swing
	                                    : rsq_pkg::osc_off;
	assign osc_amp_enable     = (osc_mode == rsq_pkg::osc_full_swing);
	assign osc_amp_force_high = (osc_mode == rsq_pkg::osc_off);

	////////////////////////////////////////////////////////////////
	// Lock status and flags

	// R18: trim, CTL0 writes or stop clear status
	assign lock_clr = stop_mode ||
	                  (apb_wr && (hit(idx, `RSQ_IDX_TRIM) ||
	                              hit(idx, `RSQ_IDX_CTL0)));
	assign lock_st_d = lock_clr ? 1'b0 : evt.lock_det;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lock_st_q <= 1'b0;
		else
			lock_st_q <= lock_st_d;
	end

	// Write-one clears of the flag register
	assign lock_change_flag_clr = apb_wr && hit(idx, `RSQ_IDX_FLAG) &&
	                    pwdata[`RSQ_FLG_LOCK_CHANGE_FLAG];
	assign power_on_flag_clr   = apb_wr && hit(idx, `RSQ_IDX_FLAG) &&
	                    pwdata[`RSQ_FLG_POR];
	assign illegal_access_flag_clr   = apb_wr && hit(idx, `RSQ_IDX_FLAG) &&
	                    pwdata[`RSQ_FLG_ILA];

	// Lock change flag, a change wins over the clear
	// R11: set on change, silent when cleared
	// R12: write one clears
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lock_change_flag_q <= 1'b0;
		else if (!lock_clr && lock_st_d != lock_st_q)
			lock_change_flag_q <= 1'b1;
		else if (lock_change_flag_clr)
			lock_change_flag_q <= 1'b0;
	end

	// Power-on flag
	// R19: set by power-on, write one clears
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			power_on_flag_q <= 1'b0;
		else if (evt.por)
			power_on_flag_q <= 1'b1;
		else if (power_on_flag_clr)
			power_on_flag_q <= 1'b0;
	end

	// Illegal access flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			illegal_access_flag_q <= 1'b0;
		else if (evt.illegal)
			illegal_access_flag_q <= 1'b1;
		else if (illegal_access_flag_clr)
			illegal_access_flag_q <= 1'b0;
	end

	// R13: enable and processor mask gate request
	assign lock_irq = lock_change_flag_q && lock_irq_enable_q && !cpu_irq_mask;

	////////////////////////////////////////////////////////////////
	// Read data

	always_comb
	begin
		flag_val                 = 8'h00;
		flag_val[`RSQ_FLG_POR]   = power_on_flag_q;
		flag_val[`RSQ_FLG_LOCK_CHANGE_FLAG] = lock_change_flag_q;
		flag_val[`RSQ_FLG_LOCK_STATUS] = lock_st_q;
		flag_val[`RSQ_FLG_ILA]   = illegal_access_flag_q;
	end

	// Read mux, unmapped words read zero
	// R14: test register reads zero
	// R15: test register readable anytime
	always_comb
	begin
		rd_val = 8'h00;
		unique case (1'b1)
			hit(idx, `RSQ_IDX_TRIM):  rd_val = trim_q;
			hit(idx, `RSQ_IDX_FLAG):  rd_val = flag_val;
			hit(idx, `RSQ_IDX_CTL1):
				rd_val = 8'(lock_irq_enable_q) << `RSQ_CTL1_LOCK_IRQ_ENABLE;
			hit(idx, `RSQ_IDX_CTL0):
				rd_val = 8'(osc_amp_output_osc_enable_q) << `RSQ_CTL0_OSC_AMP_OUTPUT_OSC_ENABLE;
			hit(idx, `RSQ_IDX_TEST0): rd_val = `RSQ_RST_TEST0;
			hit(idx, `RSQ_IDX_TEST1): rd_val = TEST1_VALUE;
			default:                  rd_val = 8'h00;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (apb_setup && !pwrite)
			prdata <= {24'h000000, rd_val};
	end

	////////////////////////////////////////////////////////////////
	// Checks

	test_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
		(apb_setup && !pwrite && hit(idx, `RSQ_IDX_TEST0)) |=>
		prdata == 32'h00000000)
		else $error("test register 0 not zero");

	lock_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
		($changed(lock_st_q) && !$past(lock_clr)) |-> lock_change_flag_q)
		else $error("lock change did not set flag");

	lock_w1c_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
		(lock_change_flag_clr && lock_st_d == lock_st_q) |=> !lock_change_flag_q)
		else $error("lock flag not cleared");

	lock_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
		lock_irq |-> (lock_change_flag_q && lock_irq_enable_q && !cpu_irq_mask))
		else $error("lock request without enable");

	stat_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
		(lock_clr && !lock_change_flag_q) |=> !lock_st_q && !lock_change_flag_q)
		else $error("status clear set flag");

	osc_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
		!osc_amp_output_osc_enable_q |-> osc_amp_force_high && !osc_amp_enable)
		else $error("amplifier output not forced high");

	oscf_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
		$rose(oscf_pend_q) |-> $past(osc_amp_output_osc_enable_q))
		else $error("oscillator failure while disabled");

	vec_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
		(seq_decide && !evt.pin_high) |=> reset_vector == rsq_pkg::vec_ext)
		else $error("low pin did not select external vector");

	pend_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
		(seq_decide && !evt.wdog) |=> !wdog_pend_q)
		else $error("watchdog pending not cleared");

	power_on_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
		evt.por |=> power_on_flag_q ##1 (power_on_flag_q || $past(power_on_flag_clr)))
		else $error("power-on flag not set");

	unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_access && !apb_mapped) |-> pslverr && pready)
		else $error("unmapped access not refused");

	vec_osc_c: cover property (@(posedge pclk) disable iff (!presetn)
		seq_decide ##1 reset_vector == rsq_pkg::vec_osc_fail);

	vec_wdog_c: cover property (@(posedge pclk) disable iff (!presetn)
		seq_decide ##1 reset_vector == rsq_pkg::vec_watchdog);

	ext_hold_c: cover property (@(posedge pclk) disable iff (!presetn)
		seq_decide && !evt.pin_high);

	lock_irq_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(lock_irq));

endmodule

`default_nettype wire

// ### bench/rsq_pin_model.sv
// Board side of the reset pin: pull-up plus an outside low driver.
// Assumes the device drives the pin low only while rst_pin_oe_n is low.
`default_nettype none

module rsq_pin_model (
	input  wire logic dev_out,
	input  wire logic dev_oe_n,
	input  wire logic ext_low,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 100ps;

	// wired low from either party, else pulled up
	assign pin = ((!dev_oe_n && !dev_out) || ext_low) ? 1'b0 : 1'b1;

endmodule

`default_nettype wire

// ### bench/tb.sv
// Self-checking bench of the reset sequencer and lock logic over APB.
// Assumes short sequence counts and the pin model on the reset pin.
`default_nettype none
`include "rsq_cfg.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int DRV = 8;
	localparam int WT  = 6;

	logic               pclk, presetn, psel, penable, pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rdata, t1_seen;
	logic               pready, pslverr, rerr, ext_low;
	logic               rst_pin_in, rst_pin_out, rst_pin_oe_n;
	logic               por_detect, illegal_access, watchdog_timeout;
	logic               osc_clk_fail, lock_detect, stop_mode, cpu_irq_mask;
	logic               sys_reset, lock_irq, osc_amp_enable;
	logic               osc_amp_force_high;
	rsq_pkg::rsq_vec_e  reset_vector;
	int                 failures = 0;
	int                 samples_checked = 0;
	int                 cycles = 0;

	////////////////////////////////////////////////////////////////////
	// Design and reset pin
	rsq_top #(.DRIVE_CYC(DRV), .WAIT_CYC(WT)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rst_pin_in(rst_pin_in),
		.rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
		.por_detect(por_detect), .illegal_access(illegal_access),
		.watchdog_timeout(watchdog_timeout), .osc_clk_fail(osc_clk_fail),
		.lock_detect(lock_detect), .stop_mode(stop_mode),
		.cpu_irq_mask(cpu_irq_mask), .sys_reset(sys_reset),
		.reset_vector(reset_vector), .lock_irq(lock_irq),
		.osc_amp_enable(osc_amp_enable),
		.osc_amp_force_high(osc_amp_force_high)
	);

	rsq_pin_model u_pin (
		.dev_out(rst_pin_out), .dev_oe_n(rst_pin_oe_n),
		.ext_low(ext_low), .pin(rst_pin_in)
	);

	////////////////////////////////////////////////////////////////////
	// Clock and hang limit
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic complete_run();
		$display("Compares %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; returns at the edge that completes it
	task automatic apb(input logic wr, input logic [5:0] idx,
		input logic [7:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Follows one sequence, checks drive length when exact is set, and checks chosen vector
	task automatic seq_check(input logic exact, input rsq_pkg::rsq_vec_e ev);
		int n;
		n = 0;
		while (rst_pin_oe_n !== 1'b0)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		n = 0;
		check(rst_pin_out, 1'b0);
		while (rst_pin_oe_n === 1'b0)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (exact) check(n == DRV || n == DRV + 1, 1);
		check(sys_reset, 1'b1);
		n = 0;
		while (sys_reset === 1'b1 && n < 2000)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		check(n >= WT - 1 && n <= WT + 2, 1);
		@(posedge pclk);
		#1;
		check({30'h0, reset_vector}, {30'h0, ev});
	endtask

	// Pulses the chosen sources {por, illegal, wdog, osc, pin} 3 cycles
	task automatic fire(input logic [4:0] ev);
		@(posedge pclk);
		{por_detect, illegal_access, watchdog_timeout, osc_clk_fail,
			ext_low} <= ev;
		fork
		begin
			repeat (3) @(posedge pclk);
			{por_detect, illegal_access, watchdog_timeout, osc_clk_fail,
				ext_low} <= 5'h00;
		end
		join_none
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{por_detect, illegal_access, watchdog_timeout, osc_clk_fail} = '0;
		{ext_low, lock_detect, stop_mode, cpu_irq_mask} = '0;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		seq_check(1'b0, rsq_pkg::vec_ext);
		// Test registers ignore writes
		apb(1'b0, `RSQ_IDX_TEST1, 8'h00);
		t1_seen = rdata;
		apb(1'b1, `RSQ_IDX_TEST0, 8'hFF);
		apb(1'b1, `RSQ_IDX_TEST1, ~t1_seen[7:0]);
		apb(1'b0, `RSQ_IDX_TEST0, 8'h00);
		check(rdata, 32'h00000000);
		apb(1'b0, `RSQ_IDX_TEST1, 8'h00);
		check(rdata, t1_seen);
		apb(1'b0, 6'h00, 8'h00);
		check(rerr, 1'b1);
		apb(1'b0, `RSQ_IDX_CTL0, 8'h00);
		check(rdata, 32'h00000000);
		check(osc_amp_force_high, 1'b1);
		// Lock change flag and request gating
		@(posedge pclk);
		lock_detect <= 1'b1;
		repeat (5) @(posedge pclk);
		apb(1'b0, `RSQ_IDX_FLAG, 8'h00);
		check(rdata[4:3], 2'h3);
		check(lock_irq, 1'b0);
		apb(1'b1, `RSQ_IDX_CTL1, 8'h01);
		#1;
		check(lock_irq, 1'b1);
		@(posedge pclk);
		cpu_irq_mask <= 1'b1;
		#1;
		check(lock_irq, 1'b0);
		@(posedge pclk);
		cpu_irq_mask <= 1'b0;
		apb(1'b1, `RSQ_IDX_FLAG, 8'h10);
		#1;
		check(lock_irq, 1'b0);
		@(posedge pclk);
		lock_detect <= 1'b0;
		repeat (5) @(posedge pclk);
		apb(1'b0, `RSQ_IDX_FLAG, 8'h00);
		check(rdata[4:3], 2'h2);
		@(posedge pclk);
		lock_detect <= 1'b1;
		repeat (5) @(posedge pclk);
		apb(1'b1, `RSQ_IDX_FLAG, 8'h10);
		// Lock loop drops out as the trim moves
		lock_detect <= 1'b0;
		apb(1'b1, `RSQ_IDX_TRIM, 8'h12);
		apb(1'b0, `RSQ_IDX_FLAG, 8'h00);
		check(rdata[4:3], 2'h0);
		// Stop mode keeps status clear with lock present
		@(posedge pclk);
		stop_mode <= 1'b1;
		lock_detect <= 1'b1;
		repeat (5) @(posedge pclk);
		apb(1'b0, `RSQ_IDX_FLAG, 8'h00);
		check(rdata[4:3], 2'h0);
		@(posedge pclk);
		stop_mode <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, `RSQ_IDX_FLAG, 8'h00);
		check(rdata[4:3], 2'h3);
		// Reset sources and vector choice
		fire(5'b00001);
		seq_check(1'b1, rsq_pkg::vec_ext);
		fire(5'b00100);
		seq_check(1'b0, rsq_pkg::vec_watchdog);
		fire(5'b00001);
		seq_check(1'b1, rsq_pkg::vec_ext);
		fire(5'b01000);
		seq_check(1'b0, rsq_pkg::vec_ext);
		apb(1'b0, `RSQ_IDX_FLAG, 8'h00);
		check(rdata[2], 1'b1);
		fire(5'b10000);
		seq_check(1'b0, rsq_pkg::vec_ext);
		apb(1'b1, `RSQ_IDX_FLAG, 8'h00);
		apb(1'b0, `RSQ_IDX_FLAG, 8'h00);
		check(rdata[6], 1'b1);
		apb(1'b1, `RSQ_IDX_FLAG, 8'h40);
		apb(1'b0, `RSQ_IDX_FLAG, 8'h00);
		check(rdata[6], 1'b0);
		apb(1'b1, `RSQ_IDX_CTL0, 8'h01);
		#1;
		check({osc_amp_enable, osc_amp_force_high}, 2'b10);
		fire(5'b00010);
		seq_check(1'b0, rsq_pkg::vec_osc_fail);
		fire(5'b00110);
		seq_check(1'b0, rsq_pkg::vec_osc_fail);
		apb(1'b1, `RSQ_IDX_CTL0, 8'h00);
		fire(5'b00010);
		repeat (20) @(posedge pclk);
		#1;
		check(sys_reset, 1'b0);
		// Pin held low past the whole sequence
		@(posedge pclk);
		ext_low <= 1'b1;
		repeat (DRV + WT + 20) @(posedge pclk);
		#1;
		check(sys_reset, 1'b1);
		@(posedge pclk);
		ext_low <= 1'b0;
		repeat (8) @(posedge pclk);
		#1;
		check(sys_reset, 1'b0);
		check({30'h0, reset_vector}, {30'h0, rsq_pkg::vec_ext});
		complete_run();
	end

endmodule

`default_nettype wire
